// ---- core/ppc_pkg.sv ----
// ppc_pkg: register map, field offsets and reset values of the pin config
package ppc_pkg;

    // ------------------------------------------------------------------
    // port numbering
    // ------------------------------------------------------------------
    localparam int NUM_PORTS   = 3;
    localparam int PORT_M      = 0;
    localparam int IRQ_PORT_A  = 1;
    localparam int IRQ_PORT_B  = 2;
    localparam int PORT_SLICE  = 8;

    // ------------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [9:0] PORT_M_DRIVE_STRENGTH_IDX = 10'h013;
    localparam logic [9:0] PORT_M_PULL_ENABLE_IDX    = 10'h014;

    // field offset inside one port's group of sixteen indices
    localparam logic [3:0] FLD_DATA      = 4'h0;
    localparam logic [3:0] FLD_INPUT     = 4'h1;
    localparam logic [3:0] FLD_DIR       = 4'h2;
    localparam logic [3:0] FLD_DRIVE     = 4'h3;
    localparam logic [3:0] FLD_PULL      = 4'h4;
    localparam logic [3:0] FLD_SELECT    = 4'h5;
    localparam logic [3:0] FLD_IRQ_EN    = 4'h6;
    localparam logic [3:0] FLD_FLAG      = 4'h7;
    localparam logic [3:0] FLD_OPENDRAIN = 4'h8;

    // group number (index bits 5:4) of each port
    localparam logic [1:0] GROUP_PORT_M =
        PORT_M_DRIVE_STRENGTH_IDX[5:4];
    localparam logic [1:0] GROUP_IRQ_A  = 2'h2;
    localparam logic [1:0] GROUP_IRQ_B  = 2'h3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PORT_M_PULL_RESET = 8'h3F;
    localparam logic [7:0] CFG_RESET         = 8'h00;
    localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;

endpackage

// ---- core/ppc_pin_irq.sv ----
// ppc_pin_irq: per-pin edge detector with sticky flags for one port
`timescale 1ns/10ps

module ppc_pin_irq #(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pinLevel,
    input  wire logic [WIDTH-1:0] edgeSelect,
    input  wire logic [WIDTH-1:0] irqEnable,
    input  wire logic [WIDTH-1:0] flagClear,
    output logic      [WIDTH-1:0] flagOut,
    output logic                  irqOut
);

    logic [WIDTH-1:0] prevLevel_reg;
    logic [2:0]       primeShift_reg;
    logic [WIDTH-1:0] edgeHit;
    logic [WIDTH-1:0] flag_next;

    // edge chosen per pin; nothing is detected while the enable is low
    assign edgeHit = primeShift_reg[2] ? (irqEnable &
        ((edgeSelect & pinLevel & ~prevLevel_reg) |
         (~edgeSelect & ~pinLevel & prevLevel_reg))) : '0;
    // a set in the same cycle as a clear wins
    assign flag_next = (flagOut & ~flagClear) | edgeHit;

    // previous level; the synchroniser ahead also restarts at zero, so
    // three edges pass before level and history both hold the real pin;
    // a pin that idles high cannot fake a rising edge, but an edge in
    // that window is lost
    always_ff @(posedge mclk) begin
        if (reset) begin
            prevLevel_reg  <= '0;
            primeShift_reg <= 3'h0;
        end else begin
            prevLevel_reg  <= pinLevel;
            primeShift_reg <= {primeShift_reg[1:0], 1'b1};
        end
    end

    // sticky flags and the registered request
    always_ff @(posedge mclk) begin
        if (reset) begin
            flagOut <= '0;
            irqOut  <= 1'b0;
        end else begin
            flagOut <= flag_next;
            irqOut  <= |(flag_next & irqEnable);
        end
    end

endmodule

// ---- core/ppc_port_config.sv ----
// ppc_port_config: apb register file and pad control for three gpio ports
//
// Contract
// - direction 0 is input; 1 drives pin to its output-level bit.
// - with pull enabled, select 0 picks pull-up, 1 picks pull-down.
// - with interrupt enabled, select 0 falling, 1 rising; else none.
// - pin interrupts exist only on the two interrupt-capable ports.
// - edge detection also works on pins set as outputs.
// - pull device acts only for input or open-drain output pins.
// - port M pins come out of reset with pull-up enabled.
// - port M drive register: six bits, 1 reduced drive, read/write.
// - reduced-drive bit is ignored while its pin is an input.
// - port M pull-enable register: six bits, 1 enables, read/write.
// - every bit returned on a read is synchronous to mclk.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps

module ppc_port_config #(
    parameter int PORT_M_WIDTH   = 6,
    parameter int IRQ_PORT_WIDTH = 8
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [23:0] padIn,
    output logic      [23:0] padOut,
    output logic      [23:0] padOe,
    output logic      [23:0] padReduced,
    output logic      [23:0] padPullUp,
    output logic      [23:0] padPullDown,
    output logic      [1:0]  pinIrq
);

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic [9:0]  regIdx;
    logic [1:0]  regGroup;
    logic [3:0]  regField;
    logic        accessSetup;
    logic        writeStrobe;
    logic [7:0]  wrByte;

    // one word per register; only the low byte carries data
    assign regIdx   = paddr[11:2];
    assign regGroup = regIdx[5:4];
    assign regField = regIdx[3:0];
    assign wrByte   = pwdata[7:0];

    // read data is captured in setup so pready and prdata both come
    // from flops; the access phase then completes in its first cycle
    assign accessSetup = psel & ~penable;
    assign writeStrobe = psel & penable & pready & pwrite;

    localparam int NUM_PORTS_L = ppc_pkg::NUM_PORTS;

    // per-port hit, field validity and readback, filled by the generate
    logic [NUM_PORTS_L-1:0] portHit;
    logic [NUM_PORTS_L-1:0] portFieldOk;
    logic [7:0]             portRdata [NUM_PORTS_L];

    // ------------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------------
    logic [23:0] padSyncA_reg;
    logic [23:0] padSyncB_reg;

    // two stages; only the second stage is looked at by any logic
    always_ff @(posedge mclk) begin
        if (reset) begin
            padSyncA_reg <= '0;
            padSyncB_reg <= '0;
        end else begin
            padSyncA_reg <= padIn;
            padSyncB_reg <= padSyncA_reg;
        end
    end

    // ------------------------------------------------------------------
    // per-port configuration and pad control
    // ------------------------------------------------------------------
    logic [1:0] irqLine;

    for (genvar p = 0; p < NUM_PORTS_L; p++) begin : portGen

        localparam bit IRQ_CAPABLE = (p != ppc_pkg::PORT_M);
        localparam int WIDTH_P =
            IRQ_CAPABLE ? IRQ_PORT_WIDTH : PORT_M_WIDTH;
        localparam logic [7:0] MASK = 8'(8'hFF >> (8 - WIDTH_P));
        localparam logic [1:0] GROUP =
            (p == ppc_pkg::PORT_M)     ? ppc_pkg::GROUP_PORT_M :
            (p == ppc_pkg::IRQ_PORT_A) ? ppc_pkg::GROUP_IRQ_A :
                                         ppc_pkg::GROUP_IRQ_B;
        localparam logic [7:0] PULL_INIT = IRQ_CAPABLE ?
            ppc_pkg::CFG_RESET : ppc_pkg::PORT_M_PULL_RESET;

        logic [7:0] dataReg;
        logic [7:0] dirReg;
        logic [7:0] driveReg;
        logic [7:0] pullReg;
        logic [7:0] selectReg;
        logic [7:0] openDrainReg;
        logic [7:0] irqEnReg;
        logic [7:0] flagVec;
        logic [7:0] inLevel;
        logic [7:0] pushPull;
        logic [7:0] pullActive;
        logic       wrHere;

        assign inLevel = padSyncB_reg[p*8 +: 8] & MASK;
        assign portHit[p] = (regIdx[9:6] == 4'h0) && (regGroup == GROUP);

        // irq fields exist only where the port is interrupt-capable
        assign portFieldOk[p] = (regField <= ppc_pkg::FLD_OPENDRAIN) &&
            (IRQ_CAPABLE || ((regField != ppc_pkg::FLD_IRQ_EN) &&
                             (regField != ppc_pkg::FLD_FLAG)));
        assign wrHere = writeStrobe & portHit[p] & portFieldOk[p];

        // software-written configuration; any time, masked to the pins
        always_ff @(posedge mclk) begin
            if (reset) begin
                dataReg      <= ppc_pkg::CFG_RESET;
                dirReg       <= ppc_pkg::CFG_RESET;
                driveReg     <= ppc_pkg::CFG_RESET;
                pullReg      <= PULL_INIT;
                selectReg    <= ppc_pkg::CFG_RESET;
                openDrainReg <= ppc_pkg::CFG_RESET;
            end else if (wrHere) begin
                case (regField)
                    ppc_pkg::FLD_DATA:      dataReg <= wrByte & MASK;
                    ppc_pkg::FLD_DIR:       dirReg <= wrByte & MASK;
                    ppc_pkg::FLD_DRIVE:     driveReg <= wrByte & MASK;
                    ppc_pkg::FLD_PULL:      pullReg <= wrByte & MASK;
                    ppc_pkg::FLD_SELECT:    selectReg <= wrByte & MASK;
                    ppc_pkg::FLD_OPENDRAIN: openDrainReg <= wrByte & MASK;
                    default: ;
                endcase
            end
        end

        if (IRQ_CAPABLE) begin : irqGen
            logic [7:0] irqEn_reg;
            logic [7:0] flagClear;

            // enable register, only on interrupt-capable ports
            always_ff @(posedge mclk) begin
                if (reset) begin
                    irqEn_reg <= ppc_pkg::CFG_RESET;
                end else if (wrHere &&
                             regField == ppc_pkg::FLD_IRQ_EN) begin
                    irqEn_reg <= wrByte & MASK;
                end
            end

            // flags clear by writing ones to the flag field
            assign flagClear = (wrHere &&
                regField == ppc_pkg::FLD_FLAG) ? (wrByte & MASK) : 8'h00;

            // edge detection sees the pin whatever its direction
            ppc_pin_irq #(
                .WIDTH      (8)
            ) u_pin_irq (
                .mclk       (mclk),
                .reset      (reset),
                .pinLevel   (inLevel),
                .edgeSelect (selectReg),
                .irqEnable  (irqEn_reg),
                .flagClear  (flagClear),
                .flagOut    (flagVec),
                .irqOut     (irqLine[p-1])
            );
            assign irqEnReg = irqEn_reg;
        end else begin : noIrqGen
            // port M carries no pin interrupt function at all
            assign irqEnReg = 8'h00;
            assign flagVec  = 8'h00;
        end

        // push-pull drives both levels; open drain only pulls low
        assign pushPull   = dirReg & ~openDrainReg;
        // pull works for inputs and open-drain outputs only
        assign pullActive = pullReg & (~dirReg | openDrainReg);

        // pad controls are registered so every pad output is a flop
        always_ff @(posedge mclk) begin
            if (reset) begin
                padOut[p*8 +: 8]      <= 8'h00;
                padOe[p*8 +: 8]       <= 8'h00;
                padReduced[p*8 +: 8]  <= 8'h00;
                padPullUp[p*8 +: 8]   <= PULL_INIT;
                padPullDown[p*8 +: 8] <= 8'h00;
            end else begin
                padOut[p*8 +: 8] <= dataReg & ~openDrainReg;
                padOe[p*8 +: 8]  <= pushPull |
                    (dirReg & openDrainReg & ~dataReg);
                padReduced[p*8 +: 8]  <= driveReg & dirReg;
                padPullUp[p*8 +: 8]   <= pullActive & ~selectReg;
                padPullDown[p*8 +: 8] <= pullActive & selectReg;
            end
        end

        // readback of this port's fields
        always_comb begin
            case (regField)
                ppc_pkg::FLD_DATA:      portRdata[p] = dataReg;
                ppc_pkg::FLD_INPUT:     portRdata[p] = inLevel;
                ppc_pkg::FLD_DIR:       portRdata[p] = dirReg;
                ppc_pkg::FLD_DRIVE:     portRdata[p] = driveReg;
                ppc_pkg::FLD_PULL:      portRdata[p] = pullReg;
                ppc_pkg::FLD_SELECT:    portRdata[p] = selectReg;
                ppc_pkg::FLD_IRQ_EN:    portRdata[p] = irqEnReg;
                ppc_pkg::FLD_FLAG:      portRdata[p] = flagVec;
                ppc_pkg::FLD_OPENDRAIN: portRdata[p] = openDrainReg;
                default:                portRdata[p] = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // apb read mux and response
    // ------------------------------------------------------------------
    logic [31:0] prdata_next;
    logic        pslverr_next;

    // address decode; anything unmapped reads zero with an error
    always_comb begin
        prdata_next  = ppc_pkg::RDATA_RESET;
        pslverr_next = 1'b0;
        if (portHit[ppc_pkg::PORT_M] && portFieldOk[ppc_pkg::PORT_M]) begin
            prdata_next = {24'h000000, portRdata[ppc_pkg::PORT_M]};
        end else if (portHit[ppc_pkg::IRQ_PORT_A] &&
                     portFieldOk[ppc_pkg::IRQ_PORT_A]) begin
            prdata_next = {24'h000000, portRdata[ppc_pkg::IRQ_PORT_A]};
        end else if (portHit[ppc_pkg::IRQ_PORT_B] &&
                     portFieldOk[ppc_pkg::IRQ_PORT_B]) begin
            prdata_next = {24'h000000, portRdata[ppc_pkg::IRQ_PORT_B]};
        end else begin
            pslverr_next = 1'b1;
        end
    end

    // response flops; pready rises for exactly the first access cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata  <= ppc_pkg::RDATA_RESET;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= accessSetup;
            if (accessSetup) begin
                prdata  <= pwrite ? ppc_pkg::RDATA_RESET : prdata_next;
                pslverr <= pslverr_next;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // pin interrupt requests
    // ------------------------------------------------------------------
    // the request already leaves the detector registered; this stage
    // keeps the top-level outputs on local flops at one cycle cost
    always_ff @(posedge mclk) begin
        if (reset) begin
            pinIrq <= 2'b00;
        end else begin
            pinIrq <= irqLine;
        end
    end

endmodule

// ---- verif/ppc_port_config_props.sv ----
// ppc_port_config_props: concurrent checks on the pin config ports
`timescale 1ns/10ps

module ppc_port_config_props (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [23:0] padIn,
    input wire logic [23:0] padOut,
    input wire logic [23:0] padOe,
    input wire logic [23:0] padPullUp,
    input wire logic [23:0] padPullDown,
    input wire logic [1:0]  pinIrq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    logic [7:0] pinPrev_reg;
    logic [3:0] quietCount_reg;

    // --------------------------------------------------------------
    // helper: cycles since port A pins or any write last moved
    // --------------------------------------------------------------
    // saturates so a long quiet spell never wraps back to small values
    always_ff @(posedge mclk) begin
        pinPrev_reg <= padIn[15:8];
        if (reset || pinPrev_reg != padIn[15:8] || (pready && pwrite)) begin
            quietCount_reg <= 4'h0;
        end else if (quietCount_reg != 4'hF) begin
            quietCount_reg <= quietCount_reg + 4'h1;
        end
    end

    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable && pready; endsequence
    property p_answer; s_setup |=> s_access ##1 !pready; endproperty
    property p_ready_cause;
        pready |-> $past(psel && !penable) && psel && penable;
    endproperty
    property p_err_ready; pslverr |-> pready; endproperty
    property p_pull_excl; (padPullUp & padPullDown) == 24'h000000; endproperty
    property p_push_no_pull;
        (padOe & padOut & (padPullUp | padPullDown)) == 24'h000000;
    endproperty
    property p_m_six;
        {padOut[7:6], padOe[7:6], padPullUp[7:6], padPullDown[7:6]} == 8'h00;
    endproperty
    property p_reset_state;
        $fell(reset) |-> padPullUp == 24'h00003F && padOe == 24'h000000
            && padPullDown == 24'h000000 && pinIrq == 2'h0;
    endproperty
    property p_drive_read;
        pready && !pwrite && paddr[11:2] == ppc_pkg::PORT_M_DRIVE_STRENGTH_IDX
            |-> prdata[31:6] == 26'h0000000;
    endproperty
    property p_pull_read;
        pready && !pwrite && paddr[11:2] == ppc_pkg::PORT_M_PULL_ENABLE_IDX
            |-> prdata[31:6] == 26'h0000000;
    endproperty
    property p_pad_after_write;
        !$stable({padOe, padPullUp, padPullDown})
            |-> $past(pready && pwrite, 2);
    endproperty
    property p_irq_cause;
        $rose(pinIrq[0]) |-> quietCount_reg <= 4'h8;
    endproperty

    a_answer: assert property (p_answer)
        else $error("bad pready timing");
    a_ready_cause: assert property (p_ready_cause)
        else $error("stray pready");
    a_err_ready: assert property (p_err_ready)
        else $error("stray pslverr");
    a_pull_excl: assert property (p_pull_excl)
        else $error("both pulls on");
    a_push_no_pull: assert property (p_push_no_pull)
        else $error("pull on push");
    a_m_six: assert property (p_m_six)
        else $error("port M bit 6/7 set");
    a_reset_state: assert property (p_reset_state)
        else $error("reset pads");
    a_drive_read: assert property (p_drive_read)
        else $error("drive width");
    a_pull_read: assert property (p_pull_read)
        else $error("pull width");
    a_pad_after_write: assert property (p_pad_after_write)
        else $error("pad moved");
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq no cause");
endmodule

bind ppc_port_config ppc_port_config_props u_props (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .padPullUp(padPullUp), .padPullDown(padPullDown), .pinIrq(pinIrq)
);

// ---- verif/ppc_port_config_tb.sv ----
// ppc_port_config_tb: apb driven self-checking bench for the pin config
`timescale 1ns/10ps

module ppc_port_config_tb;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [23:0] padIn = 24'h000000;
    logic [31:0] prdata, rdData;
    logic        pready, pslverr, rdErr;
    logic [23:0] padOut, padOe, padReduced, padPullUp, padPullDown;
    logic [1:0]  pinIrq;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cycles = 0;

    ppc_port_config dut (
        .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .padReduced(padReduced), .padPullUp(padPullUp),
        .padPullDown(padPullDown), .pinIrq(pinIrq)
    );

    // ------------------------------------------------------------------
    // clock, watchdog and closing report
    // ------------------------------------------------------------------
    always #5 mclk = ~mclk;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // the whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", name, e, g);
            fail_count++;
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [9:0] idx,
                       input logic [7:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) chk("pready", 32'h1, 32'h0);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // pads follow one edge after the write edge
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
        @(posedge mclk);
        #1;
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk("prdata", {24'h000000, e}, rdData);
    endtask

    task automatic pins(input logic [23:0] v, input int n);
        @(posedge mclk);
        padIn <= v;
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        chk("pullUp", 32'h3F, {8'h00, padPullUp});
        rd(ppc_pkg::PORT_M_PULL_ENABLE_IDX, 8'h3F);
        rd(ppc_pkg::PORT_M_DRIVE_STRENGTH_IDX, 8'h00);
        wr(ppc_pkg::PORT_M_DRIVE_STRENGTH_IDX, 8'hFF);
        rd(ppc_pkg::PORT_M_DRIVE_STRENGTH_IDX, 8'h3F);
        wr(ppc_pkg::PORT_M_PULL_ENABLE_IDX, 8'h15);
        rd(ppc_pkg::PORT_M_PULL_ENABLE_IDX, 8'h15);
        chk("pullUp", 32'h15, {8'h00, padPullUp});
        chk("reduced", 32'h00, {8'h00, padReduced});
        wr(10'h015, 8'h3F);
        chk("pullDown", 32'h15, {8'h00, padPullDown});
        chk("pullUp", 32'h00, {8'h00, padPullUp});
        // low four pins driven, the upper two stay inputs
        wr(10'h010, 8'h05);
        wr(10'h012, 8'h0F);
        chk("oe", 32'h0F, {8'h00, padOe});
        chk("out", 32'h05, {8'h00, padOut});
        chk("reduced", 32'h0F, {8'h00, padReduced});
        chk("pullDown", 32'h10, {8'h00, padPullDown});
        // pin 0 open drain at level 1: released, its pull comes back
        wr(10'h010, 8'h07);
        wr(10'h018, 8'h01);
        chk("oe", 32'h0E, {8'h00, padOe});
        chk("out", 32'h06, {8'h00, padOut});
        chk("pullDown", 32'h11, {8'h00, padPullDown});
        apb(1'b0, 10'h016, 8'h00);
        chk("pslverr", 32'h1, {31'h0, rdErr});
        chk("prdata", 32'h0, rdData);
        // port A pin 0 rising; other port A pins and port B disabled
        wr(10'h025, 8'h01);
        wr(10'h026, 8'h01);
        pins(24'h00FEFF, 8);
        chk("pinIrq", 32'h0, {30'h0, pinIrq});
        pins(24'h00FFFF, 6);
        chk("pinIrq", 32'h1, {30'h0, pinIrq});
        rd(10'h027, 8'h01);
        wr(10'h027, 8'h01);
        repeat (4) @(posedge mclk);
        chk("pinIrq", 32'h0, {30'h0, pinIrq});
        // port B pin 0 as output, falling edge selected
        wr(10'h032, 8'h01);
        wr(10'h035, 8'h00);
        wr(10'h036, 8'h01);
        pins(24'h01FFFF, 8);
        chk("pinIrq", 32'h0, {30'h0, pinIrq});
        pins(24'h00FFFF, 6);
        chk("pinIrq", 32'h2, {30'h0, pinIrq});
        stop_test();
    end
endmodule
